/* File: shared/bbsx_pkg.sv */
// Purpose: constants and types for the bit, branch, shift and move execution unit
// Assumes: 14-bit instruction word, 128-entry file window, 15-bit program counter
// Notes: opcode encodings are local to this unit
// Contract
// - bit clear zeroes chosen bit of addressed file register, flags unchanged.
// - bit set forces chosen bit to one, other bits and flags unchanged.
// - skip-if-clear discards next instruction as no-op when tested bit is zero.
// - skip-if-set discards next instruction as no-op when tested bit is one.
// - relative jump adds sign-extended 9-bit literal to incremented counter, two cycles.
// - accumulator jump adds unsigned working register to incremented counter, two cycles.
// - left shift puts bit 7 in carry, zero into bit 0, updates carry and zero.
// - right shift puts bit 0 in carry, zero into bit 7, updates carry and zero.
// - shift destination select zero writes working register, one writes file register.
// - file move copies to working register or back to itself, one cycle.
// - file move updates zero flag even when written back to itself.
`default_nettype none

package bbsx_pkg;
    localparam int PC_W   = 15;
    localparam int ADDR_W = 7;
    localparam int INSN_W = 14;
    localparam int LIT_W  = 9;

    localparam logic [7:0]        W_RESET   = 8'h00;
    localparam logic [PC_W-1:0]   PC_RESET  = 15'h0000;
    localparam logic [INSN_W-1:0] NOP_WORD  = 14'h0000;

    // opcode field positions
    localparam int OP_BIT_HI  = 13;
    localparam int OP_BIT_LO  = 10;
    localparam int BIT_IDX_LO = 7;
    localparam int DEST_POS   = 7;

    // upper four bits for bit-oriented operations
    localparam logic [3:0] OP_BIT_CLEAR = 4'h4;
    localparam logic [3:0] OP_BIT_SET   = 4'h5;
    localparam logic [3:0] OP_SKIP_CLR  = 4'h6;
    localparam logic [3:0] OP_SKIP_SET  = 4'h7;
    // upper five bits for the relative jump
    localparam logic [4:0] OP_REL_JUMP  = 5'h19;
    // upper six bits for byte-oriented operations; the accumulator jump is a full 14-bit word
    localparam logic [5:0] OP_MOVE_FILE = 6'h08;
    localparam logic [5:0] OP_SHIFT_L   = 6'h35;
    localparam logic [5:0] OP_SHIFT_R   = 6'h36;
    localparam logic [INSN_W-1:0] OP_ACC_JUMP = 14'h000B;

    typedef enum logic [3:0] {
        BBSX_OP_NONE, BBSX_OP_BCLR, BBSX_OP_BSET, BBSX_OP_SKC, BBSX_OP_SKS,
        BBSX_OP_REL, BBSX_OP_ACC, BBSX_OP_SHL, BBSX_OP_SHR, BBSX_OP_MOV
    } bbsx_op_t;

    typedef struct packed {
        bbsx_op_t          op;
        logic [ADDR_W-1:0] addr;
        logic [2:0]        bit_idx;
        logic              dest_file;
        logic [LIT_W-1:0]  lit;
    } bbsx_dec_t;

    typedef struct packed {
        logic       we;
        logic [ADDR_W-1:0] addr;
        logic [7:0] data;
    } bbsx_fwr_t;

    // executor states, gray along exec->flush->exec
    typedef enum logic [1:0] {
        BBSX_ST_EXEC  = 2'h0,
        BBSX_ST_FLUSH = 2'h1
    } bbsx_state_t;
endpackage

`default_nettype wire

/* File: design/bbsx_decode.sv */
// Purpose: combinational decode of one instruction word
// Assumes: word is stable for the cycle in which it is executed
// Notes: unknown words decode to BBSX_OP_NONE and act as a no-op
`default_nettype none

module bbsx_decode
    import bbsx_pkg::*;
(
    input  wire logic [INSN_W-1:0] i_insn,
    output bbsx_dec_t              o_dec
);
    always_comb begin
        o_dec           = '0;
        o_dec.op        = BBSX_OP_NONE;
        o_dec.addr      = i_insn[ADDR_W-1:0];
        o_dec.bit_idx   = i_insn[BIT_IDX_LO+2:BIT_IDX_LO];
        o_dec.dest_file = i_insn[DEST_POS];
        o_dec.lit       = i_insn[LIT_W-1:0];
        if (i_insn == OP_ACC_JUMP) begin
            o_dec.op = BBSX_OP_ACC;
        end else if (i_insn[OP_BIT_HI:OP_BIT_LO] == OP_BIT_CLEAR) begin
            o_dec.op = BBSX_OP_BCLR;
        end else if (i_insn[OP_BIT_HI:OP_BIT_LO] == OP_BIT_SET) begin
            o_dec.op = BBSX_OP_BSET;
        end else if (i_insn[OP_BIT_HI:OP_BIT_LO] == OP_SKIP_CLR) begin
            o_dec.op = BBSX_OP_SKC;
        end else if (i_insn[OP_BIT_HI:OP_BIT_LO] == OP_SKIP_SET) begin
            o_dec.op = BBSX_OP_SKS;
        end else if (i_insn[OP_BIT_HI:OP_BIT_HI-4] == OP_REL_JUMP) begin
            o_dec.op = BBSX_OP_REL;
        end else if (i_insn[OP_BIT_HI:OP_BIT_HI-5] == OP_SHIFT_L) begin
            o_dec.op = BBSX_OP_SHL;
        end else if (i_insn[OP_BIT_HI:OP_BIT_HI-5] == OP_SHIFT_R) begin
            o_dec.op = BBSX_OP_SHR;
        end else if (i_insn[OP_BIT_HI:OP_BIT_HI-5] == OP_MOVE_FILE) begin
            o_dec.op = BBSX_OP_MOV;
        end
    end
endmodule // bbsx_decode

`default_nettype wire

/* File: design/bbsx_exec.sv */
// Purpose: executes bit, skip, branch, shift and move instructions
// Assumes: I_CORE_CLK is the instruction clock; file read data is combinational
// Notes: one instruction offered per cycle; I_INSN_VALID low stalls nothing but idles
`default_nettype none

module bbsx_exec
    import bbsx_pkg::*;
(
    input  wire logic              I_CORE_CLK,
    input  wire logic              I_RST,
    input  wire logic              I_INSN_VALID,
    input  wire logic [INSN_W-1:0] I_INSN,
    input  wire logic [7:0]        I_FILE_RDATA,
    output logic [ADDR_W-1:0]      O_FILE_RADDR_UNUSED,
    output logic                   O_FILE_WE,
    output logic [ADDR_W-1:0]      O_FILE_WADDR,
    output logic [7:0]             O_FILE_WDATA,
    output logic [7:0]             O_W,
    output logic                   O_CARRY,
    output logic                   O_ZERO,
    output logic [PC_W-1:0]        O_PC,
    output logic                   O_FLUSH,
    output logic                   O_RETIRE
);
    bbsx_dec_t    dec;
    bbsx_state_t  state_reg;
    logic [PC_W-1:0] pc_reg;
    logic [7:0]   w_reg;
    logic         c_reg;
    logic         z_reg;
    bbsx_fwr_t    fwr_reg;
    logic         flush_reg;
    logic         retire_reg;
    logic [7:0]   result;
    logic         res_carry;
    logic         tested_bit;
    logic         go;
    logic         do_skip;
    logic         do_jump;
    logic [PC_W-1:0] pc_inc;
    logic [PC_W-1:0] jump_tgt;

    bbsx_decode i_bbsx_decode (
        .i_insn (I_INSN),
        .o_dec  (dec)
    );

    // a flushed slot is executed as a no-op
    assign go         = I_INSN_VALID && (state_reg == BBSX_ST_EXEC);
    assign tested_bit = I_FILE_RDATA[dec.bit_idx];
    assign pc_inc     = pc_reg + 15'h0001;

    always_comb begin
        result    = I_FILE_RDATA;
        res_carry = c_reg;
        case (dec.op)
            BBSX_OP_BCLR: result = I_FILE_RDATA & ~(8'h01 << dec.bit_idx);
            BBSX_OP_BSET: result = I_FILE_RDATA | (8'h01 << dec.bit_idx);
            BBSX_OP_SHL: begin
                result    = {I_FILE_RDATA[6:0], 1'h0};
                res_carry = I_FILE_RDATA[7];
            end
            BBSX_OP_SHR: begin
                result    = {1'h0, I_FILE_RDATA[7:1]};
                res_carry = I_FILE_RDATA[0];
            end
            default: result = I_FILE_RDATA;
        endcase
    end

    always_comb begin
        do_skip = 1'h0;
        do_jump = 1'h0;
        jump_tgt = pc_inc;
        case (dec.op)
            BBSX_OP_SKC: do_skip = !tested_bit;
            BBSX_OP_SKS: do_skip = tested_bit;
            BBSX_OP_REL: begin
                do_jump  = 1'h1;
                jump_tgt = pc_inc + {{(PC_W-LIT_W){dec.lit[LIT_W-1]}}, dec.lit};
            end
            BBSX_OP_ACC: begin
                do_jump  = 1'h1;
                jump_tgt = pc_inc + {7'h00, w_reg};
            end
            default: do_jump = 1'h0;
        endcase
    end

    // flush state: the slot after a skip or jump is discarded
    always_ff @(posedge I_CORE_CLK) begin
        if (I_RST) begin
            state_reg <= BBSX_ST_EXEC;
        end else begin
            case (state_reg)
                BBSX_ST_EXEC: begin
                    if (go && (do_skip || do_jump)) begin
                        state_reg <= BBSX_ST_FLUSH;
                    end
                end
                BBSX_ST_FLUSH: begin
                    // an idle cycle does not use up the discard
                    if (I_INSN_VALID) begin
                        state_reg <= BBSX_ST_EXEC;
                    end
                end
                default: state_reg <= BBSX_ST_EXEC;
            endcase
        end
    end

    always_ff @(posedge I_CORE_CLK) begin
        if (I_RST) begin
            pc_reg <= PC_RESET;
        end else if (go && do_jump) begin
            pc_reg <= jump_tgt;
        end else if (I_INSN_VALID) begin
            pc_reg <= pc_inc;
        end
    end

    // working register: only shifts and move with destination zero
    always_ff @(posedge I_CORE_CLK) begin
        if (I_RST) begin
            w_reg <= W_RESET;
        end else if (go && !dec.dest_file
                     && (dec.op == BBSX_OP_SHL || dec.op == BBSX_OP_SHR || dec.op == BBSX_OP_MOV)) begin
            w_reg <= result;
        end
    end

    // flags: bit ops, skips and jumps leave them alone
    always_ff @(posedge I_CORE_CLK) begin
        if (I_RST) begin
            c_reg <= 1'h0;
            z_reg <= 1'h0;
        end else if (go) begin
            if (dec.op == BBSX_OP_SHL || dec.op == BBSX_OP_SHR) begin
                c_reg <= res_carry;
                z_reg <= (result == 8'h00);
            end else if (dec.op == BBSX_OP_MOV) begin
                z_reg <= (result == 8'h00);
            end
        end
    end

    // file write-back; a move to itself rewrites the same value
    always_ff @(posedge I_CORE_CLK) begin
        if (I_RST) begin
            fwr_reg <= '0;
        end else begin
            fwr_reg.addr <= dec.addr;
            fwr_reg.data <= result;
            fwr_reg.we   <= go && ((dec.op == BBSX_OP_BCLR) || (dec.op == BBSX_OP_BSET)
                            || (dec.dest_file && (dec.op == BBSX_OP_SHL || dec.op == BBSX_OP_SHR
                            || dec.op == BBSX_OP_MOV)));
        end
    end

    always_ff @(posedge I_CORE_CLK) begin
        if (I_RST) begin
            flush_reg  <= 1'h0;
            retire_reg <= 1'h0;
        end else begin
            flush_reg  <= go && (do_skip || do_jump);
            retire_reg <= I_INSN_VALID;
        end
    end

    assign O_FILE_RADDR_UNUSED = fwr_reg.addr;
    assign O_FILE_WE    = fwr_reg.we;
    assign O_FILE_WADDR = fwr_reg.addr;
    assign O_FILE_WDATA = fwr_reg.data;
    assign O_W          = w_reg;
    assign O_CARRY      = c_reg;
    assign O_ZERO       = z_reg;
    assign O_PC         = pc_reg;
    assign O_FLUSH      = flush_reg;
    assign O_RETIRE     = retire_reg;

    property p_bclr_clears;
        @(posedge I_CORE_CLK) disable iff (I_RST)
        go && dec.op == BBSX_OP_BCLR |=> O_FILE_WE && !O_FILE_WDATA[$past(dec.bit_idx)] && $stable(O_CARRY);
    endproperty
    a_bclr_clears: assert property (p_bclr_clears) else $error("bit clear left bit set");

    property p_bset_sets;
        @(posedge I_CORE_CLK) disable iff (I_RST)
        go && dec.op == BBSX_OP_BSET |=> O_FILE_WE && O_FILE_WDATA[$past(dec.bit_idx)] && $stable(O_ZERO);
    endproperty
    a_bset_sets: assert property (p_bset_sets) else $error("bit set wrong");

    property p_skc_flush;
        @(posedge I_CORE_CLK) disable iff (I_RST)
        go && dec.op == BBSX_OP_SKC && !tested_bit |=> state_reg == BBSX_ST_FLUSH && O_FLUSH;
    endproperty
    a_skc_flush: assert property (p_skc_flush) else $error("skip if clear missed");

    property p_sks_flush;
        @(posedge I_CORE_CLK) disable iff (I_RST)
        go && dec.op == BBSX_OP_SKS |=> O_FLUSH == $past(tested_bit);
    endproperty
    a_sks_flush: assert property (p_sks_flush) else $error("skip if set wrong");

    property p_rel_target;
        @(posedge I_CORE_CLK) disable iff (I_RST)
        go && dec.op == BBSX_OP_REL |=> O_PC == $past(pc_reg) + 15'h0001
            + {{(PC_W-LIT_W){$past(I_INSN[LIT_W-1])}}, $past(I_INSN[LIT_W-1:0])} && $stable(O_CARRY);
    endproperty
    a_rel_target: assert property (p_rel_target) else $error("relative jump target wrong");

    property p_acc_target;
        @(posedge I_CORE_CLK) disable iff (I_RST)
        go && dec.op == BBSX_OP_ACC |=> O_PC == $past(pc_reg) + 15'h0001 + {7'h00, $past(w_reg)};
    endproperty
    a_acc_target: assert property (p_acc_target) else $error("accumulator jump target wrong");

    property p_shl_carry;
        @(posedge I_CORE_CLK) disable iff (I_RST)
        go && dec.op == BBSX_OP_SHL |=> O_CARRY == $past(I_FILE_RDATA[7]);
    endproperty
    a_shl_carry: assert property (p_shl_carry) else $error("left shift carry wrong");

    property p_shr_carry;
        @(posedge I_CORE_CLK) disable iff (I_RST)
        go && dec.op == BBSX_OP_SHR |=> O_CARRY == $past(I_FILE_RDATA[0]);
    endproperty
    a_shr_carry: assert property (p_shr_carry) else $error("right shift carry wrong");

    property p_mov_zero;
        @(posedge I_CORE_CLK) disable iff (I_RST)
        go && dec.op == BBSX_OP_MOV |=> O_ZERO == ($past(I_FILE_RDATA) == 8'h00);
    endproperty
    a_mov_zero: assert property (p_mov_zero) else $error("move zero flag wrong");
endmodule // bbsx_exec

`default_nettype wire

/* File: verification/bbsx_exec_tb.sv */
// Purpose: self-checking bench for the bit, skip, jump, shift and move executor
// Assumes: one word offered per task, results read 1 ns after the taking edge
// Notes: expected state is tracked here, never read back from the design
`default_nettype none

module bbsx_exec_tb
    import bbsx_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;

    logic              core_clk;
    logic              rst;
    logic              insn_valid;
    logic [INSN_W-1:0] insn;
    logic [7:0]        file_rdata;
    logic [ADDR_W-1:0] file_raddr;
    logic              file_we;
    logic [ADDR_W-1:0] file_waddr;
    logic [7:0]        file_wdata;
    logic [7:0]        w_out;
    logic              carry;
    logic              zero;
    logic [PC_W-1:0]   pc;
    logic              flush;
    logic              retire;
    int                miscompares;
    int                cmp_count;
    int                cycles;
    logic [7:0]        w_e;
    logic              c_e;
    logic              z_e;
    logic [PC_W-1:0]   pc_e;

    bbsx_exec i_bbsx_exec (
        .I_CORE_CLK         (core_clk),
        .I_RST              (rst),
        .I_INSN_VALID       (insn_valid),
        .I_INSN             (insn),
        .I_FILE_RDATA       (file_rdata),
        .O_FILE_RADDR_UNUSED(file_raddr),
        .O_FILE_WE          (file_we),
        .O_FILE_WADDR       (file_waddr),
        .O_FILE_WDATA       (file_wdata),
        .O_W                (w_out),
        .O_CARRY            (carry),
        .O_ZERO             (zero),
        .O_PC               (pc),
        .O_FLUSH            (flush),
        .O_RETIRE           (retire)
    );

    always #2 core_clk = ~core_clk;

    task automatic print_verdict();
        $display("comparisons %0d, mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // about 105 cycles of work; a hang ends at cycle 3000
    always @(posedge core_clk) begin
        cycles = cycles + 1;
        if (cycles == 3000) begin
            miscompares++;
            print_verdict();
        end
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // offer one word, then compare every output against the tracked state, skipping write address and data when no write is expected
    task automatic run(input logic [INSN_W-1:0] word, input logic [7:0] rd, input logic we,
                       input logic [7:0] wd, input logic fl, input logic [PC_W-1:0] step);
        @(posedge core_clk);
        insn_valid <= 1'h1;
        insn       <= word;
        file_rdata <= rd;
        @(posedge core_clk);
        insn_valid <= 1'h0;
        file_rdata <= ~rd;
        #1;
        pc_e = pc_e + step;
        chk(16'(file_we), 16'(we));
        chk(16'(file_raddr), 16'(word[6:0]));
        if (we) begin
            chk(16'(file_waddr), 16'(word[6:0]));
            chk(16'(file_wdata), 16'(wd));
        end
        chk(16'(w_out), 16'(w_e));
        chk(16'(carry), 16'(c_e));
        chk(16'(zero), 16'(z_e));
        chk(16'(pc), 16'(pc_e));
        chk(16'(flush), 16'(fl));
        chk(16'(retire), 16'h0001);
    endtask

    task automatic t_reset();
        @(posedge core_clk);
        #1;
        chk(16'({file_we, flush, retire, carry, zero}), 16'h0000);
        chk(16'(w_out), 16'(W_RESET));
        chk(16'(pc), 16'(PC_RESET));
        $display("test reset done");
    endtask

    task automatic t_shift();
        w_e = 8'h02;
        c_e = 1'h1;
        run({OP_SHIFT_L, 1'h0, 7'h10}, 8'h81, 1'h0, 8'h00, 1'h0, 15'h0001);
        c_e = 1'h1;
        z_e = 1'h1;
        run({OP_SHIFT_L, 1'h1, 7'h11}, 8'h80, 1'h1, 8'h00, 1'h0, 15'h0001);
        c_e = 1'h0;
        z_e = 1'h0;
        run({OP_SHIFT_R, 1'h1, 7'h12}, 8'hFE, 1'h1, 8'h7F, 1'h0, 15'h0001);
        w_e = 8'h80;
        run({OP_SHIFT_L, 1'h0, 7'h13}, 8'h40, 1'h0, 8'h00, 1'h0, 15'h0001);
        w_e = 8'h00;
        c_e = 1'h1;
        z_e = 1'h1;
        run({OP_SHIFT_R, 1'h0, 7'h14}, 8'h01, 1'h0, 8'h00, 1'h0, 15'h0001);
        $display("test shift done");
    endtask

    // both flags are set here, so any flag change shows up
    task automatic t_bits();
        for (int b = 0; b < 8; b++) begin
            run({OP_BIT_CLEAR, 3'(b), 7'h7F}, 8'hFF, 1'h1, 8'hFF & ~(8'h01 << b), 1'h0, 15'h0001);
            run({OP_BIT_SET, 3'(b), 7'h00}, 8'h00, 1'h1, 8'h01 << b, 1'h0, 15'h0001);
        end
        run({OP_BIT_SET, 3'h3, 7'h31}, 8'hA5, 1'h1, 8'hAD, 1'h0, 15'h0001);
        run({OP_BIT_CLEAR, 3'h0, 7'h32}, 8'h5A, 1'h1, 8'h5A, 1'h0, 15'h0001);
        $display("test bits done");
    endtask

    task automatic t_move();
        w_e = 8'hC3;
        z_e = 1'h0;
        run({OP_MOVE_FILE, 1'h0, 7'h05}, 8'hC3, 1'h0, 8'h00, 1'h0, 15'h0001);
        w_e = 8'h00;
        z_e = 1'h1;
        run({OP_MOVE_FILE, 1'h0, 7'h06}, 8'h00, 1'h0, 8'h00, 1'h0, 15'h0001);
        z_e = 1'h0;
        run({OP_MOVE_FILE, 1'h1, 7'h45}, 8'h5A, 1'h1, 8'h5A, 1'h0, 15'h0001);
        z_e = 1'h1;
        run({OP_MOVE_FILE, 1'h1, 7'h7F}, 8'h00, 1'h1, 8'h00, 1'h0, 15'h0001);
        $display("test move done");
    endtask

    // a swallowed word must write nothing and leave W and flags alone
    task automatic t_skip();
        run({OP_SKIP_CLR, 3'h2, 7'h20}, 8'hFB, 1'h0, 8'h00, 1'h1, 15'h0001);
        run({OP_BIT_SET, 3'h0, 7'h21}, 8'h00, 1'h0, 8'h00, 1'h0, 15'h0001);
        run({OP_SKIP_CLR, 3'h2, 7'h20}, 8'h04, 1'h0, 8'h00, 1'h0, 15'h0001);
        run({OP_SKIP_SET, 3'h7, 7'h22}, 8'h80, 1'h0, 8'h00, 1'h1, 15'h0001);
        run({OP_MOVE_FILE, 1'h0, 7'h23}, 8'h77, 1'h0, 8'h00, 1'h0, 15'h0001);
        run({OP_SKIP_SET, 3'h7, 7'h22}, 8'h7F, 1'h0, 8'h00, 1'h0, 15'h0001);
        $display("test skip done");
    endtask

    task automatic t_jump();
        run({OP_REL_JUMP, 9'h0FF}, 8'h00, 1'h0, 8'h00, 1'h1, 15'h0100);
        run({OP_BIT_SET, 3'h1, 7'h24}, 8'h00, 1'h0, 8'h00, 1'h0, 15'h0001);
        run({OP_REL_JUMP, 9'h100}, 8'h00, 1'h0, 8'h00, 1'h1, 15'h7F01);
        run({OP_SHIFT_L, 1'h0, 7'h25}, 8'h81, 1'h0, 8'h00, 1'h0, 15'h0001);
        w_e = 8'hFF;
        z_e = 1'h0;
        run({OP_MOVE_FILE, 1'h0, 7'h26}, 8'hFF, 1'h0, 8'h00, 1'h0, 15'h0001);
        run(OP_ACC_JUMP, 8'h00, 1'h0, 8'h00, 1'h1, 15'h0100);
        run({OP_BIT_CLEAR, 3'h4, 7'h27}, 8'hFF, 1'h0, 8'h00, 1'h0, 15'h0001);
        $display("test jump done");
    endtask

    // reset while a discard is pending: the word after release must execute
    task automatic t_mid_reset();
        run({OP_SKIP_SET, 3'h0, 7'h28}, 8'h01, 1'h0, 8'h00, 1'h1, 15'h0001);
        @(posedge core_clk);
        rst <= 1'h1;
        repeat (2) @(posedge core_clk);
        rst  <= 1'h0;
        w_e  = W_RESET;
        c_e  = 1'h0;
        z_e  = 1'h0;
        pc_e = PC_RESET;
        t_reset();
        w_e = 8'h3C;
        run({OP_MOVE_FILE, 1'h0, 7'h29}, 8'h3C, 1'h0, 8'h00, 1'h0, 15'h0001);
        $display("test mid-run reset done");
    endtask

    initial begin
        core_clk    = 1'h0;
        rst         = 1'h1;
        insn_valid  = 1'h0;
        insn        = NOP_WORD;
        file_rdata  = 8'h00;
        miscompares = 0;
        cmp_count   = 0;
        cycles      = 0;
        w_e         = W_RESET;
        c_e         = 1'h0;
        z_e         = 1'h0;
        pc_e        = PC_RESET;
        repeat (16) @(posedge core_clk);
        rst <= 1'h0;
        t_reset();
        t_shift();
        t_bits();
        t_move();
        t_skip();
        t_jump();
        t_mid_reset();
        print_verdict();
    end
endmodule // bbsx_exec_tb

`default_nettype wire
